// file: core/agsch_map.vh
// Purpose: register offsets, reset values and timing counts of the group scheduler
// Assumes: byte addresses on a 32-bit bus, one register per aligned word
// Notes: only haddr[7:0] is decoded
`ifndef AGSCH_MAP_VH
`define AGSCH_MAP_VH
////////////////////////////////////////////////////////////////////////////////
// global registers
`define AGSCH_OFS_EXEC 8'h00
`define AGSCH_OFS_ENTRY 8'h04
`define AGSCH_OFS_DONE 8'h08
`define AGSCH_OFS_ONESHOT 8'h0c
`define AGSCH_OFS_LOOP 8'h10
// sample period of channel c at base + 4*c, c = 0 to 15
`define AGSCH_OFS_SMP_BASE 8'h40
// group g block at base + 16*g: word 0 chan mask, 1 event mask, 2 trigger select
`define AGSCH_OFS_GRP_BASE 8'h80
`define AGSCH_GRP_CMASK 2'd0
`define AGSCH_GRP_EMASK 2'd1
`define AGSCH_GRP_TSEL 2'd2
////////////////////////////////////////////////////////////////////////////////
// reset values
`define AGSCH_RST_GRP8 8'h00
`define AGSCH_RST_MASK16 16'h0000
`define AGSCH_RST_TSEL 6'h00
`define AGSCH_RST_SMP 8'h00
`define AGSCH_TSEL_NONE 6'h00
////////////////////////////////////////////////////////////////////////////////
// timing counts in clock cycles
`define AGSCH_CYC_FIRST 9'd13
`define AGSCH_CYC_NEXT 9'd12
`define AGSCH_CYC_SAR 9'd12
`define AGSCH_SMP_ZERO_CYC 9'd256
`endif

// file: core/agsch_scheduler.v
// Purpose: group scheduler of a successive-approximation converter
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: the analog core follows conv_chan_o and sample_o
//
// Overview of operation
// - eight groups 0 to 7, each with trigger, channel mask, event mask, done flag.
// - execution status, one bit per group, 1 means executing.
// - entry status, one bit per group, 1 means a request is pending.
// - the two bits give stopped, idling, final channel, mid-sequence.
// - a trigger sets entry; execution bit is left alone.
// - lowest-numbered entered group is picked; trigger order does not matter.
// - masked channels of the running group convert in ascending order.
// - triggers to an already entered group are ignored.
// - entry clears when the last masked channel starts converting.
// - single-channel group clears entry as it becomes executing.
// - after its last channel a group sets its done flag.
// - many triggers while entered give one run; re-entry needs a new trigger.
// - loop request bit triggers its group every cycle.
// - channel mask held as low and high byte, bit n is channel n.
// - each group has its own per-channel event mask, low and high byte.
// - a finished channel with its event bit set raises the group event.
// - event, one-shot write and loop request act as the same trigger.
// - trigger select 0 means none; one number may serve many groups.
// - trigger numbers 1 to 57 map onto event sources; 16, 17 unused.
// - first channel from idle takes sample plus 13, later ones plus 12.
// - sample period 1 to 256 cycles, value zero means 256.
// - done flags stay until cleared; a coinciding hardware set wins.
// - loop trigger starts one cycle after a one-shot trigger would.
//
// Our own choices: the AHB-Lite register port and the address map.
`include "agsch_map.vh"
module agsch_scheduler (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// ahb-lite slave
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output wire [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	// event triggers, bit n is trigger number n
	input wire [63:0] trig_evt_i,
	// status
	output wire [7:0] exec_status_o,
	output wire [7:0] entry_status_o,
	output wire [7:0] done_flags_o,
	// conversion core side
	output wire conv_active_o,
	output wire sample_o,
	output wire [3:0] conv_chan_o,
	output wire [2:0] conv_group_o,
	output wire chan_done_o,
	output wire [7:0] group_event_o
);

	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// lowest set bit helpers, bit 4 or 3 set means none
	function [4:0] first16;
		input [15:0] v;
		integer k;
		begin
			first16 = 5'h10;
			for (k = 15; k >= 0; k = k - 1) begin
				if (v[k])
					first16 = k[4:0];
			end
		end
	endfunction

	function [3:0] first8;
		input [7:0] v;
		integer k;
		begin
			first8 = 4'h8;
			for (k = 7; k >= 0; k = k - 1) begin
				if (v[k])
					first8 = k[3:0];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state
	reg state_reg;
	reg state_next;
	reg [2:0] grp_reg;
	reg [2:0] grp_next;
	reg [3:0] chan_reg;
	reg [3:0] chan_next;
	reg [15:0] rem_reg;
	reg [15:0] rem_next;
	reg [8:0] cnt_reg;
	reg [8:0] cnt_next;
	reg [7:0] exec_reg;
	reg [7:0] exec_next;
	reg [7:0] entry_reg;
	reg [7:0] entry_next;
	reg [7:0] done_reg;
	reg [7:0] done_next;
	reg [7:0] loop_reg;
	reg [7:0] evt_reg;
	reg [7:0] evt_next;
	reg cdone_reg;
	reg cdone_next;
	reg sample_reg;
	reg [15:0] cmask_reg [0:7];
	reg [15:0] emask_reg [0:7];
	reg [5:0] tsel_reg [0:7];
	reg [7:0] smp_reg [0:15];
	// bus data phase
	reg dp_valid_reg;
	reg dp_write_reg;
	reg [7:0] dp_addr_reg;
	reg [31:0] hrdata_reg;
	reg [31:0] rd_val;

	wire [7:0] evt_hit;
	wire [7:0] trig_vec;
	wire [7:0] pend;
	wire ap_take;
	wire wr_en;
	wire wr_grp;
	wire wr_smp;
	wire [2:0] wr_g;
	wire [1:0] wr_w;
	wire [7:0] oneshot_pulse;
	wire [7:0] done_clr;
	wire [3:0] first_pend;

	////////////////////////////////////////////////////////////////////////////
	// event trigger match per group
	// select value zero never matches, so trigger line 0 starts nothing
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_hit
			assign evt_hit[g] = (tsel_reg[g] != `AGSCH_TSEL_NONE) && trig_evt_i[tsel_reg[g]];
		end
	endgenerate

	// all trigger kinds merge into one vector
	assign trig_vec = evt_hit | oneshot_pulse | loop_reg;
	// a repeat trigger to an entered group lands on a bit already set and leaves no trace
	assign pend = entry_reg | trig_vec;

	// lowest pending group, code 8 when none is pending
	assign first_pend = first8(pend);

	////////////////////////////////////////////////////////////////////////////
	// bus decode; only the low address byte is decoded, so the map repeats every 256 bytes
	assign ap_take = hsel_i && hready_i && htrans_i[1];
	assign wr_en = dp_valid_reg && dp_write_reg;
	assign wr_grp = wr_en && dp_addr_reg[7];
	assign wr_smp = wr_en && ({dp_addr_reg[7:6], 6'h00} == `AGSCH_OFS_SMP_BASE);
	assign wr_g = dp_addr_reg[6:4];
	assign wr_w = dp_addr_reg[3:2];
	// a one-shot write acts in its data phase only; reads of that word return zero
	assign oneshot_pulse = (wr_en && dp_addr_reg == `AGSCH_OFS_ONESHOT) ? hwdata_i[7:0] : 8'h00;
	assign done_clr = (wr_en && dp_addr_reg == `AGSCH_OFS_DONE) ? hwdata_i[7:0] : 8'h00;

	// read value, captured at the address phase
	// hazard: a write still in its data phase is not yet seen by a read right behind it
	always @* begin
		rd_val = 32'h0000_0000;
		if (haddr_i[7:0] == `AGSCH_OFS_EXEC) begin
			rd_val[7:0] = exec_reg;
		end else if (haddr_i[7:0] == `AGSCH_OFS_ENTRY) begin
			rd_val[7:0] = entry_reg;
		end else if (haddr_i[7:0] == `AGSCH_OFS_DONE) begin
			rd_val[7:0] = done_reg;
		end else if (haddr_i[7:0] == `AGSCH_OFS_LOOP) begin
			rd_val[7:0] = loop_reg;
		end else if ({haddr_i[7:6], 6'h00} == `AGSCH_OFS_SMP_BASE) begin
			rd_val[7:0] = smp_reg[haddr_i[5:2]];
		end else if (haddr_i[7] && haddr_i[3:2] == `AGSCH_GRP_CMASK) begin
			rd_val[15:0] = cmask_reg[haddr_i[6:4]];
		end else if (haddr_i[7] && haddr_i[3:2] == `AGSCH_GRP_EMASK) begin
			rd_val[15:0] = emask_reg[haddr_i[6:4]];
		end else if (haddr_i[7] && haddr_i[3:2] == `AGSCH_GRP_TSEL) begin
			rd_val[5:0] = tsel_reg[haddr_i[6:4]];
		end
	end

	// bus pipeline and configuration storage
	// hready low holds the captured address phase over a stalled data phase
	integer i;
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
			loop_reg <= `AGSCH_RST_GRP8;
			for (i = 0; i < 8; i = i + 1) begin
				cmask_reg[i] <= `AGSCH_RST_MASK16;
				emask_reg[i] <= `AGSCH_RST_MASK16;
				tsel_reg[i] <= `AGSCH_RST_TSEL;
			end
			for (i = 0; i < 16; i = i + 1) begin
				smp_reg[i] <= `AGSCH_RST_SMP;
			end
		end else begin
			if (hready_i) begin
				dp_valid_reg <= ap_take;
				dp_write_reg <= hwrite_i;
				dp_addr_reg <= haddr_i[7:0];
			end
			if (ap_take && !hwrite_i)
				hrdata_reg <= rd_val;
			// the loop bits act from the cycle after their write, one later than a one-shot
			if (wr_en && dp_addr_reg == `AGSCH_OFS_LOOP)
				loop_reg <= hwdata_i[7:0];
			if (wr_smp)
				smp_reg[dp_addr_reg[5:2]] <= hwdata_i[7:0];
			if (wr_grp && wr_w == `AGSCH_GRP_CMASK)
				cmask_reg[wr_g] <= hwdata_i[15:0];
			if (wr_grp && wr_w == `AGSCH_GRP_EMASK)
				emask_reg[wr_g] <= hwdata_i[15:0];
			if (wr_grp && wr_w == `AGSCH_GRP_TSEL)
				tsel_reg[wr_g] <= hwdata_i[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scheduler next state
	reg do_start;
	reg start_first;
	reg do_next;
	reg [2:0] sg;
	reg [4:0] ch;
	reg [15:0] m;
	reg [8:0] smp;
	always @* begin
		do_start = 1'b0;
		start_first = 1'b0;
		do_next = 1'b0;
		sg = 3'd0;
		ch = 5'd0;
		m = 16'h0000;
		smp = 9'd0;
		state_next = state_reg;
		grp_next = grp_reg;
		chan_next = chan_reg;
		rem_next = rem_reg;
		cnt_next = cnt_reg;
		exec_next = exec_reg;
		entry_next = pend;
		// software clears here and hardware sets further down, so a set in the same cycle wins
		done_next = done_reg & ~done_clr;
		evt_next = 8'h00;
		cdone_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (pend != 8'h00) begin
					do_start = 1'b1;
					start_first = 1'b1;
					sg = first_pend[2:0];
				end
			end
			ST_RUN: begin
				if (cnt_reg == 9'd1) begin
					cdone_next = 1'b1;
					evt_next[grp_reg] = emask_reg[grp_reg][chan_reg];
					if (rem_reg != 16'h0000) begin
						do_next = 1'b1;
					end else begin
						done_next[grp_reg] = 1'b1;
						exec_next[grp_reg] = 1'b0;
						state_next = ST_IDLE;
						if (pend != 8'h00) begin
							do_start = 1'b1;
							sg = first_pend[2:0];
						end
					end
				end else begin
					cnt_next = cnt_reg - 9'd1;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// the counter holds the cycles left in the channel: sampling first, then the sar steps
		// next channel of the running group
		if (do_next) begin
			ch = first16(rem_reg);
			rem_next = rem_reg & ~(16'h0001 << ch[3:0]);
			chan_next = ch[3:0];
			smp = (smp_reg[ch[3:0]] == 8'h00) ? `AGSCH_SMP_ZERO_CYC : {1'b0, smp_reg[ch[3:0]]};
			cnt_next = smp + `AGSCH_CYC_NEXT;
			if (rem_next == 16'h0000)
				entry_next[grp_reg] = 1'b0;
		end
		// group start, empty mask finishes at once
		if (do_start) begin
			m = cmask_reg[sg];
			if (m == 16'h0000) begin
				entry_next[sg] = 1'b0;
				done_next[sg] = 1'b1;
				state_next = ST_IDLE;
			end else begin
				ch = first16(m);
				exec_next[sg] = 1'b1;
				grp_next = sg;
				chan_next = ch[3:0];
				rem_next = m & ~(16'h0001 << ch[3:0]);
				smp = (smp_reg[ch[3:0]] == 8'h00) ? `AGSCH_SMP_ZERO_CYC : {1'b0, smp_reg[ch[3:0]]};
				// the idle cycle that took the trigger is the first of the 13, so one less is left to count
				cnt_next = smp + (start_first ? `AGSCH_CYC_FIRST - 9'd1 : `AGSCH_CYC_NEXT);
				state_next = ST_RUN;
				// a trigger that meets this clear in the same cycle is lost; the clear wins
				if (rem_next == 16'h0000)
					entry_next[sg] = 1'b0;
			end
		end
	end

	// group state per group from the two status bits:
	// exec 0 entry 0 stopped, exec 0 entry 1 idling,
	// exec 1 entry 0 final channel, exec 1 entry 1 mid-sequence or rerun pending
	// scheduler registers
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			grp_reg <= 3'd0;
			chan_reg <= 4'd0;
			rem_reg <= 16'h0000;
			cnt_reg <= 9'd0;
			exec_reg <= `AGSCH_RST_GRP8;
			entry_reg <= `AGSCH_RST_GRP8;
			done_reg <= `AGSCH_RST_GRP8;
			evt_reg <= 8'h00;
			cdone_reg <= 1'b0;
			sample_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			grp_reg <= grp_next;
			chan_reg <= chan_next;
			rem_reg <= rem_next;
			cnt_reg <= cnt_next;
			exec_reg <= exec_next;
			entry_reg <= entry_next;
			done_reg <= done_next;
			evt_reg <= evt_next;
			cdone_reg <= cdone_next;
			// sampling stands while more than the sar steps remain
			sample_reg <= (state_next == ST_RUN) && (cnt_next > `AGSCH_CYC_SAR);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = 1'b1; // no wait states
	assign hresp_o = 1'b0; // always okay
	assign exec_status_o = exec_reg;
	assign entry_status_o = entry_reg;
	assign done_flags_o = done_reg;
	assign conv_active_o = state_reg;
	assign sample_o = sample_reg;
	assign conv_chan_o = chan_reg;
	assign conv_group_o = grp_reg;
	assign chan_done_o = cdone_reg;
	assign group_event_o = evt_reg;

endmodule // agsch_scheduler

// file: bench/agsch_asserts.sv
// Purpose: port checks of the group scheduler
// Assumes: one clock, reset active low
// Notes: bound to agsch_scheduler below
module agsch_asserts (
	// clock, reset and bus
	input wire clock_i,
	input wire rst_n_i,
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire hready_i,
	// status and core side
	input wire [7:0] exec_status_o,
	input wire [7:0] done_flags_o,
	input wire conv_active_o,
	input wire sample_o,
	input wire chan_done_o,
	input wire [7:0] group_event_o
);
	timeunit 1ns;
	timeprecision 1ps;
	reg clr_ph;
	// marks the data phase of a write to the done flags
	always @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i) clr_ph <= 1'b0;
		else clr_ph <= hsel_i & hready_i & htrans_i[1] & hwrite_i & (haddr_i[7:0] == 8'h08);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	a_one_group_runs: assert property ($onehot0(exec_status_o)) else $error("two groups executing");
	a_sample_in_run: assert property (sample_o |-> conv_active_o) else $error("sampling while idle");
	a_start_samples: assert property ($rose(conv_active_o) |-> ##[0:1] sample_o) else $error("no sampling");
	a_min_channel: assert property ($rose(conv_active_o) |-> conv_active_o [*8]) else $error("channel short");
	a_sar_twelve: assert property ($fell(sample_o) |-> ##[11:13] chan_done_o) else $error("bad sar length");
	a_end_pulses: assert property ($fell(conv_active_o) |-> chan_done_o) else $error("end without pulse");
	a_event_with_done: assert property (|group_event_o |-> chan_done_o && $onehot(group_event_o))
		else $error("stray group event");
	a_done_sticky: assert property (!$past(clr_ph) |-> (done_flags_o & $past(done_flags_o)) == $past(done_flags_o))
		else $error("done flag lost");
	a_done_at_end: assert property ((done_flags_o & ~$past(done_flags_o)) != 8'h00 |-> chan_done_o)
		else $error("done set mid run");
endmodule // agsch_asserts
bind agsch_scheduler agsch_asserts u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
	.exec_status_o(exec_status_o), .done_flags_o(done_flags_o), .conv_active_o(conv_active_o),
	.sample_o(sample_o), .chan_done_o(chan_done_o), .group_event_o(group_event_o));

// file: bench/agsch_evt_src.sv
// Purpose: event trigger sources seen by the scheduler
// Assumes: one pulse a request, one cycle long
// Notes: gated sources need the event controller on
module agsch_evt_src (
	// clock and request
	input wire clock_i,
	input wire fire_i,
	input wire [5:0] num_i,
	input wire evc_en_i,
	// trigger lines
	output reg [63:0] trig_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin and processor-unit sources are silent while the controller is off
	wire gated = (num_i >= 6'h01 && num_i <= 6'h09) || num_i >= 6'h22;
	initial trig_o = 64'h0;
	// one pulse a request; 16 and 17 have no source
	always @(posedge clock_i)
		trig_o <= (fire_i && (evc_en_i || !gated) && num_i != 6'h10 && num_i != 6'h11) ? 64'h1 << num_i : 64'h0;
endmodule // agsch_evt_src

// file: bench/agsch_tb.sv
// Purpose: self-checking bench of the group scheduler
// Assumes: 8 ns clock, reset low for six cycles
// Notes: random channels and periods from a fixed seed
`include "agsch_map.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, rst_n_i, hsel, hwrite, fire, evc_en, smp_d;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, q;
	logic [5:0] num;
	logic [15:0] m6;
	logic [7:0] smp[16];
	logic [7:0] seen_q[$], exp_q[$];
	wire hready;
	wire [31:0] hrdata;
	wire [63:0] trig;
	wire [7:0] exec_o, entry_o, done_o, gev_o;
	wire act_o, samp_o, cdone_o;
	wire [3:0] chan_o;
	wire [2:0] grp_o;
	int err_count, checked, n, ch, em;
	agsch_scheduler dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .trig_evt_i(trig), .exec_status_o(exec_o),
		.entry_status_o(entry_o), .done_flags_o(done_o), .conv_active_o(act_o), .sample_o(samp_o),
		.conv_chan_o(chan_o), .conv_group_o(grp_o), .chan_done_o(cdone_o), .group_event_o(gev_o));
	agsch_evt_src src (.clock_i(clock_i), .fire_i(fire), .num_i(num), .evc_en_i(evc_en), .trig_o(trig));
	////////////////////////////////////////////////////////////////////////////////
	// compare, bus and wait tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		@(posedge clock_i);
		while (hready !== 1'b1) @(posedge clock_i);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clock_i);
		while (hready !== 1'b1) @(posedge clock_i);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic set_grp(input int g, input logic [15:0] cm, input logic [15:0] e, input logic [5:0] ts);
		wr(8'(8'h80 + 16 * g), {16'h0, cm});
		wr(8'(8'h84 + 16 * g), {16'h0, e});
		wr(8'(8'h88 + 16 * g), {26'h0, ts});
	endtask
	task automatic fire_evt(input int k);
		num <= 6'(k);
		fire <= 1'b1;
		@(posedge clock_i);
		fire <= 1'b0;
		@(posedge clock_i);
		#1;
	endtask
	task automatic wait_done(output int k);
		k = 0;
		do begin
			@(posedge clock_i);
			k++;
		end while (cdone_o !== 1'b1 && k < 600);
	endtask
	task automatic wait_quiet;
		for (int k = 0; k < 3000 && (exec_o | entry_o) !== 8'h00; k++) @(posedge clock_i);
	endtask
	task automatic add_grp(input logic [2:0] g, input logic [15:0] m);
		for (int c = 0; c < 16; c++) if (m[c]) exp_q.push_back({1'b0, g, 4'(c)});
	endtask
	function automatic int cyc(input logic [7:0] s);
		return (s == 8'h00 ? 256 : int'(s)) + 13;
	endfunction
	task automatic final_report;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// clock, watchdog and channel-start monitor
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	initial begin
		repeat (60000) @(posedge clock_i);
		err_count++;
		final_report;
	end
	always @(posedge clock_i) begin
		smp_d <= samp_o;
		if (samp_o && !smp_d) seen_q.push_back({1'b0, grp_o, chan_o});
	end
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst_n_i, hsel, hwrite, fire, evc_en, htrans, haddr, hwdata, num} = '0;
		void'($urandom(32'h40a8));
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		for (int a = 0; a < 256; a += 4) rdchk(8'(a), 32'h0, "reset word");
		for (int c = 0; c < 16; c++) begin
			smp[c] = 8'(1 + $urandom % 4);
			wr(8'(8'h40 + 4 * c), {24'h0, smp[c]});
		end
		// single channel group, short and longest sample period
		for (int i = 0; i < 2; i++) begin
			ch = $urandom % 16;
			em = $urandom % 2;
			smp[ch] = i ? 8'h00 : 8'(1 + $urandom % 8);
			wr(8'(8'h40 + 4 * ch), {24'h0, smp[ch]});
			set_grp(0, 16'h1 << ch, 16'(em) << ch, 6'h00);
			wr(`AGSCH_OFS_ONESHOT, 32'h1);
			#1 chk("exec", 32'h1, exec_o);
			chk("entry", 32'h0, entry_o);
			chk("active", 32'h1, act_o);
			wait_done(n);
			chk("cycles", cyc(smp[ch]), n);
			chk("event", em, gev_o);
			chk("done", 32'h1, done_o);
			wr(`AGSCH_OFS_DONE, 32'hff);
			rdchk(`AGSCH_OFS_DONE, 32'h0, "done clear");
		end
		// lower group triggered later runs first, repeats ignored
		seen_q = {};
		ch = $urandom % 15;
		m6 = 16'h0010 | 16'(32'h1 << ($urandom % 16));
		set_grp(5, 16'h8000 | 16'h1 << ch, 16'h0, 6'h00);
		set_grp(3, 16'h1 << ch, 16'h0, 6'h00);
		set_grp(6, m6, 16'hffff, 6'h00);
		add_grp(3'h5, 16'h8000 | 16'h1 << ch);
		add_grp(3'h3, 16'h1 << ch);
		add_grp(3'h6, m6);
		wr(`AGSCH_OFS_ONESHOT, 32'h20);
		#1 chk("entry mid", 32'h20, entry_o);
		wr(`AGSCH_OFS_ONESHOT, 32'h20);
		wr(`AGSCH_OFS_ONESHOT, 32'h40);
		wr(`AGSCH_OFS_ONESHOT, 32'h08);
		wait_quiet;
		chk("runs", exp_q.size(), seen_q.size());
		foreach (exp_q[i]) chk("order", exp_q[i], seen_q[i]);
		chk("done", 32'h68, done_o);
		// one event number shared by two groups; number zero selects none
		n = 1 + $urandom % 57;
		if (n == 16 || n == 17) n = 18;
		set_grp(4, 16'h1 << ch, 16'hffff, 6'(n));
		set_grp(7, 16'h1 << ch, 16'h0, 6'(n));
		set_grp(1, 16'h1, 16'h0, 6'h00);
		evc_en <= 1'b1;
		fire_evt(n);
		wait_quiet;
		chk("event runs", 32'hf8, done_o);
		fire_evt(0);
		chk("no select", 32'h0, exec_o | entry_o);
		// loop request keeps group 2 re-entered
		set_grp(2, 16'h1 << ch, 16'h0, 6'h00);
		wr(`AGSCH_OFS_LOOP, 32'h4);
		wait_done(n);
		chk("loop start", cyc(smp[ch]) + 1, n);
		wait_done(n);
		chk("loop again", cyc(smp[ch]) - 1, n);
		rdchk(`AGSCH_OFS_LOOP, 32'h4, "loop reg");
		wr(`AGSCH_OFS_LOOP, 32'h0);
		wait_quiet;
		chk("loop stop", 32'h0, exec_o | entry_o);
		final_report;
	end
endmodule // testbench
